// *** common/key_wake_map.svh ***
/*
  Register offsets, field positions, reset values and response codes
  of the key wake unit.
  Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
*/
`ifndef KEY_WAKE_MAP_SVH
`define KEY_WAKE_MAP_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define KW_PIN_W        8
`define KW_ADDR_W       8
`define KW_DATA_W       32
`define KW_STRB_W       4

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define KW_OFS_STATUS   8'h00
`define KW_OFS_ENABLE   8'h04
`define KW_OFS_POLARITY 8'h08

// ----------------------------------------------------------------
// key_status_control fields
// ----------------------------------------------------------------
`define KW_BIT_MODE     0
`define KW_BIT_IE       1
`define KW_BIT_ACK      2
`define KW_BIT_FLAG     3

// ----------------------------------------------------------------
// reset values and bonded pins
// ----------------------------------------------------------------
`define KW_RST_STATUS   8'h00
`define KW_RST_ENABLE   8'h00
`define KW_RST_POLARITY 8'h00
`define KW_RST_STATUS_MODE_BIT 1'b0
`define KW_BONDED_MASK  8'h7F

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define KW_RESP_OKAY    2'h0
`define KW_RESP_SLVERR  2'h2

`endif

// *** common/key_wake_pkg.sv ***
/*
  Types shared by the key wake unit and its synchroniser.
  Assumes key_wake_map.svh on the include path.
*/
`include "key_wake_map.svh"

package key_wake_pkg;

  typedef logic [`KW_PIN_W-1:0]  pin_vec_t;
  typedef logic [`KW_ADDR_W-1:0] addr_t;
  typedef logic [`KW_DATA_W-1:0] data_t;
  typedef logic [`KW_STRB_W-1:0] strb_t;

  // ----------------------------------------------------------------
  // synchroniser state
  // ----------------------------------------------------------------
  typedef struct packed {
    pin_vec_t meta;
    pin_vec_t stable;
  } sync_s;

  // ----------------------------------------------------------------
  // unit state
  // ----------------------------------------------------------------
  typedef struct packed {
    pin_vec_t   pin_enable;
    pin_vec_t   polarity;
    pin_vec_t   sample_prev;
    logic       irq_enable;
    logic       detect_mode;
    logic       event_flag;
    logic       armed;
    logic       aw_full;
    addr_t      aw_addr;
    logic       w_full;
    data_t      w_data;
    strb_t      w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    data_t      rdata;
    logic [1:0] rresp;
  } state_s;

endpackage

// *** rtl/key_wake_sync.sv ***
/*
  Two-stage synchroniser for the wake input pins.
  Assumes pins are asynchronous to aclk; only the second stage is used.
*/
`timescale 1ns/1ps

module key_wake_sync
  import key_wake_pkg::*;
(
  // clock and reset
  input  logic                  aclk,
  input  logic                  aresetn,
  // pins in, synchronised out
  input  key_wake_pkg::pin_vec_t async_in,
  output key_wake_pkg::pin_vec_t sync_out
);

  sync_s sync_reg;
  sync_s sync_next;

  // ----------------------------------------------------------------
  // two flops in a row
  // ----------------------------------------------------------------
  always_comb
  begin
    sync_next        = sync_reg;
    sync_next.meta   = async_in;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_reg <= '0;
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg.stable;

endmodule

// *** rtl/key_wake_interrupt.sv ***
/*
  Key wake interrupt unit: pin enables, polarity selects, edge or
  edge-and-level detection, shared event flag with write-one
  acknowledge, AXI4-Lite register slave.
  Assumes pins are asynchronous, a single 100 MHz aclk, and a power
  controller that drives the stop mode inputs.
*/
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "key_wake_map.svh"

// Contract
// RQ1 - falling edge: enabled pin sampled high, then low next cycle
// RQ2 - rising polarity: pin sampled low, then high next cycle
// RQ3 - outside drives enabled inputs deasserted before first edge counts
// RQ4 - after an edge, ignore edges until all enabled inputs deassert
// RQ5 - valid edge, or level in level mode, sets event flag
// RQ6 - flag set and interrupt enabled presents interrupt request
// RQ7 - writing 1 to acknowledge bit 2 clears flag; bit reads 0
// RQ8 - flag at bit 3 is read-only, reads 1 after event
// RQ9 - status bits 7 to 4 always read 0
// RQ10 - bit 1 enables interrupt requests
// RQ11 - bit 0 selects edge only or edge and level for all pins
// RQ12 - each pin enable bit enables its pin as source
// RQ13 - polarity bit 0 falling/low, 1 rising/high
// RQ14 - keeps working in wait mode and can wake processor
// RQ15 - in shallow stop, detects pins without clock, wakes processor
// RQ16 - deep stop disables unit; registers return to reset state
// RQ17 - debug mode behaves exactly like run mode
// RQ18 - seven bonded pins; unused enable position has no pin
// RQ19 - acknowledge fails while any enabled input stays asserted
// RQ20 - software masks, sets polarity, enables, acknowledges, then enables
// RQ21 - pins pass a two-stage synchroniser before edge comparison
module key_wake_interrupt
  import key_wake_pkg::*;
#(
  parameter key_wake_pkg::pin_vec_t BONDED_MASK = `KW_BONDED_MASK
)
(
  // clock and reset
  input  logic                   aclk,
  input  logic                   aresetn,
  // write address channel
  input  key_wake_pkg::addr_t    awaddr,
  input  logic [2:0]             awprot,
  input  logic                   awvalid,
  output logic                   awready,
  // write data channel
  input  key_wake_pkg::data_t    wdata,
  input  key_wake_pkg::strb_t    wstrb,
  input  logic                   wvalid,
  output logic                   wready,
  // write response channel
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  logic                   bready,
  // read address channel
  input  key_wake_pkg::addr_t    araddr,
  input  logic [2:0]             arprot,
  input  logic                   arvalid,
  output logic                   arready,
  // read data channel
  output key_wake_pkg::data_t    rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  logic                   rready,
  // key pins
  input  key_wake_pkg::pin_vec_t wake_input_pins,
  // power modes
  input  logic                   shallow_stop_mode,
  input  logic                   deep_stop_mode,
  // requests
  output logic                   key_irq,
  output logic                   wake_request
);

  import key_wake_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic pin_vec_t asserted_pins(
    input pin_vec_t level,
    input pin_vec_t pol,
    input pin_vec_t en
  );
    asserted_pins = en & BONDED_MASK & ~(level ^ pol);
  endfunction

  function automatic logic [2:0] decode_addr(input addr_t addr);
    decode_addr = 3'h0;
    if (addr == `KW_OFS_STATUS)
    begin
      decode_addr = 3'h1;
    end
    else if (addr == `KW_OFS_ENABLE)
    begin
      decode_addr = 3'h2;
    end
    else if (addr == `KW_OFS_POLARITY)
    begin
      decode_addr = 3'h4;
    end
  endfunction

  function automatic logic [7:0] status_byte(input state_s s);
    status_byte                = 8'h00;
    status_byte[`KW_BIT_MODE]  = s.detect_mode;
    status_byte[`KW_BIT_IE]    = s.irq_enable;
    status_byte[`KW_BIT_FLAG]  = s.event_flag;
  endfunction

  function automatic logic [1:0] resp_code(input logic [2:0] sel);
    resp_code = `KW_RESP_OKAY;
    if (sel == 3'h0)
    begin
      resp_code = `KW_RESP_SLVERR;
    end
  endfunction

  function automatic pin_vec_t low_byte(input data_t d);
    low_byte = d[`KW_PIN_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_s   state_reg;
  state_s   state_next;
  pin_vec_t pins_sync;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  key_wake_sync u_sync
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (wake_input_pins),
    .sync_out (pins_sync)
  ); // [RQ21]

  // ----------------------------------------------------------------
  // detection terms
  // ----------------------------------------------------------------
  pin_vec_t   now_asserted;
  pin_vec_t   prev_asserted;
  pin_vec_t   raw_asserted;
  logic       any_asserted;
  logic       edge_seen;
  logic       level_seen;
  logic       event_set;
  logic [2:0] aw_sel;
  logic [2:0] ar_sel;
  logic       write_fire;
  logic       read_fire;
  logic       ack_write;
  logic       ack_clear;

  always_comb
  begin
    now_asserted  = asserted_pins(pins_sync, state_reg.polarity,
                                  state_reg.pin_enable); // [RQ12] [RQ13]
    prev_asserted = asserted_pins(state_reg.sample_prev,
                                  state_reg.polarity,
                                  state_reg.pin_enable);
    raw_asserted  = asserted_pins(wake_input_pins, state_reg.polarity,
                                  state_reg.pin_enable); // [RQ18]
    any_asserted  = |now_asserted;
    // deasserted one cycle, asserted the next
    edge_seen     = state_reg.armed
                    & (|(now_asserted & ~prev_asserted)); // [RQ1] [RQ2]
    level_seen    = state_reg.detect_mode & any_asserted; // [RQ11]
    event_set     = edge_seen | level_seen; // [RQ5] [RQ17]
  end

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  always_comb
  begin
    awready    = !state_reg.aw_full && !state_reg.bvalid;
    wready     = !state_reg.w_full && !state_reg.bvalid;
    arready    = !state_reg.rvalid;
    aw_sel     = decode_addr(state_reg.aw_addr);
    ar_sel     = decode_addr(araddr);
    write_fire = state_reg.aw_full && state_reg.w_full
                 && !state_reg.bvalid;
    read_fire  = arvalid && arready;
    ack_write  = write_fire && aw_sel[0] && state_reg.w_strb[0]
                 && state_reg.w_data[`KW_BIT_ACK]; // [RQ7]
    ack_clear  = ack_write && !any_asserted; // [RQ19]
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next             = state_reg;
    state_next.sample_prev = pins_sync;

    // re-arm once every enabled input is back at rest
    if (edge_seen)
    begin
      state_next.armed = 1'b0; // [RQ4]
    end
    else if (!any_asserted)
    begin
      state_next.armed = 1'b1; // [RQ3] [RQ4]
    end

    // flag: set beats acknowledge in the same cycle
    state_next.event_flag = event_set
                            | (state_reg.event_flag & ~ack_clear);
                            // [RQ5] [RQ7] [RQ8]

    // write address and data latches
    if (awvalid && awready)
    begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      state_next.w_full = 1'b1;
      state_next.w_data = wdata;
      state_next.w_strb = wstrb;
    end

    // register write
    if (write_fire)
    begin
      state_next.aw_full = 1'b0;
      state_next.w_full  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = resp_code(aw_sel);
      if (state_reg.w_strb[0])
      begin
        if (aw_sel[0])
        begin
          state_next.detect_mode =
            state_reg.w_data[`KW_BIT_MODE]; // [RQ11]
          state_next.irq_enable  =
            state_reg.w_data[`KW_BIT_IE]; // [RQ10]
        end
        if (aw_sel[1])
        begin
          state_next.pin_enable =
            low_byte(state_reg.w_data); // [RQ12]
        end
        if (aw_sel[2])
        begin
          state_next.polarity =
            low_byte(state_reg.w_data); // [RQ13]
        end
      end
    end
    else if (state_reg.bvalid && bready)
    begin
      state_next.bvalid = 1'b0;
    end

    // register read
    if (read_fire)
    begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = resp_code(ar_sel);
      state_next.rdata  = '0;
      unique case (ar_sel)
        3'h1:
        begin
          state_next.rdata[7:0] = status_byte(state_reg);
          // [RQ7] [RQ8] [RQ9]
        end
        3'h2:
        begin
          state_next.rdata[`KW_PIN_W-1:0] = state_reg.pin_enable;
        end
        3'h4:
        begin
          state_next.rdata[`KW_PIN_W-1:0] = state_reg.polarity;
        end
        default:
        begin
          state_next.rresp = `KW_RESP_SLVERR;
        end
      endcase
    end
    else if (state_reg.rvalid && rready)
    begin
      state_next.rvalid = 1'b0;
    end

    // deep stop returns the register fields, flag and arming to their reset state
    if (deep_stop_mode)
    begin
      state_next.pin_enable  = `KW_RST_ENABLE; // [RQ16]
      state_next.polarity    = `KW_RST_POLARITY;
      state_next.detect_mode = `KW_RST_STATUS_MODE_BIT;
      state_next.irq_enable  = 1'b0;
      state_next.event_flag  = 1'b0;
      state_next.armed       = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg             <= '0;
      state_reg.pin_enable  <= `KW_RST_ENABLE;
      state_reg.polarity    <= `KW_RST_POLARITY;
      state_reg.bresp       <= `KW_RESP_OKAY;
      state_reg.rresp       <= `KW_RESP_OKAY;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    bvalid  = state_reg.bvalid;
    bresp   = state_reg.bresp;
    rvalid  = state_reg.rvalid;
    rdata   = state_reg.rdata;
    rresp   = state_reg.rresp;
    // request in run, wait and debug alike
    key_irq = state_reg.event_flag & state_reg.irq_enable;
    // [RQ6] [RQ10] [RQ14] [RQ17]
    // clockless path while the bus clock is stopped
    wake_request = key_irq
                   | (shallow_stop_mode & state_reg.irq_enable
                      & (|raw_asserted)); // [RQ15]
  end

endmodule

// *** sim/key_switches.sv ***
/*
  Key switch model driving the wake input pins.
  Assumes the bench sets press and the matching polarity.
*/
`timescale 1ns/1ps

module key_switches
(
  // clock
  input  logic       aclk,
  // switch control
  input  logic [7:0] press,
  input  logic [7:0] pol,
  // pins
  output logic [7:0] pins
);
  // released keys rest at the deasserted level
  always_ff @(posedge aclk)
  begin
    pins <= ~(press ^ pol);
  end
endmodule

// *** sim/key_wake_interrupt_assertions.sv ***
/*
  Checker for bus answers and request outputs of the key wake unit.
  Assumes it is bound to key_wake_interrupt.
*/
`timescale 1ns/1ps

module key_wake_interrupt_assertions
  import key_wake_pkg::*;
(
  // clock and reset
  input logic       aclk,
  input logic       aresetn,
  // bus
  input logic       awvalid,
  input logic       awready,
  input logic       wvalid,
  input logic       wready,
  input logic [1:0] bresp,
  input logic       bvalid,
  input logic       bready,
  input addr_t      araddr,
  input logic       arvalid,
  input logic       arready,
  input data_t      rdata,
  input logic [1:0] rresp,
  input logic       rvalid,
  input logic       rready,
  // modes and requests
  input logic       shallow_stop_mode,
  input logic       deep_stop_mode,
  input logic       key_irq,
  input logic       wake_request
);
  addr_t rd_addr_reg;

  always_ff @(posedge aclk)
  begin
    if (arvalid && arready)
    begin
      rd_addr_reg <= araddr;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_read_taken;
    arvalid && arready;
  endsequence

  property p_write_ans;
    s_both_taken |-> ##2 bvalid;
  endproperty
  a_write_ans: assert property (p_write_ans)
    else $error("write answer late");
  property p_read_ans;
    s_read_taken |=> rvalid;
  endproperty
  a_read_ans: assert property (p_read_ans)
    else $error("read answer late");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  property p_status_read;
    rvalid && rd_addr_reg == 8'h00 |-> (rdata & 32'hFFFFFFF4) == 32'h0;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status reserved bits set");
  property p_irq_wake;
    key_irq |-> wake_request;
  endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("request without wake");
  property p_irq_stands;
    key_irq && !deep_stop_mode |=> key_irq || $rose(bvalid);
  endproperty
  a_irq_stands: assert property (p_irq_stands)
    else $error("request dropped without a write");
  property p_run_wake;
    !shallow_stop_mode && !key_irq |-> !wake_request;
  endproperty
  a_run_wake: assert property (p_run_wake)
    else $error("wake outside stop");
  property p_deep;
    deep_stop_mode |=> !key_irq;
  endproperty
  a_deep: assert property (p_deep)
    else $error("request in deep stop");
endmodule

bind key_wake_interrupt key_wake_interrupt_assertions i_chk (.aclk,
  .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .rready, .shallow_stop_mode, .deep_stop_mode, .key_irq,
  .wake_request);

// *** sim/tb_top.sv ***
/*
  Self-checking bench of the key wake unit.
  Assumes key_switches model and the bound checker.
*/
`timescale 1ns/1ps

module tb_top;
  import key_wake_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sstop, dstop, key_irq, wake;
  logic [2:0] awprot, arprot;
  logic [1:0] bresp, rresp;
  addr_t awaddr, araddr;
  data_t wdata, rdata;
  strb_t wstrb;
  pin_vec_t pins, press, pol;
  logic [7:0] rnd;
  logic [33:0] exp_q[$];
  int miscompares, checked, cyc;

  key_wake_interrupt i_dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .wake_input_pins(pins), .shallow_stop_mode(sstop),
    .deep_stop_mode(dstop), .key_irq, .wake_request(wake));
  key_switches i_keys (.aclk, .press, .pol, .pins);

  initial
  begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input addr_t a, input data_t d, input logic [1:0] r);
    logic da, dw;
    da = 0;
    dw = 0;
    exp_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw))
    begin
      @(posedge aclk);
      if (awready && !da)
      begin
        da = 1;
        awvalid <= 1'b0;
      end
      if (wready && !dw)
      begin
        dw = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
  endtask

  task automatic rd(input addr_t a, input data_t d, input logic [1:0] r);
    exp_q.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
  endtask

  task automatic key(input pin_vec_t p);
    press <= p;
    repeat (8) @(posedge aclk);
  endtask

  // response monitor
  always @(posedge aclk)
  begin
    if (bvalid && bready && exp_q.size() > 0)
      chk({bresp, 32'h0}, exp_q.pop_front());
    if (rvalid && rready && exp_q.size() > 0)
      chk({rresp, rdata}, exp_q.pop_front());
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      summarize();
    end
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, sstop, dstop} = '0;
    {awprot, arprot, awaddr, araddr, wdata, press, pol} = '0;
    wstrb = 4'hF;
    aresetn = 0;
    rnd = 8'h2A;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 3; i++)
      rd(8'(4 * i), 32'h0, 2'h0);
    rd(8'h0C, 32'h0, 2'h2);
    wr(8'h0C, 32'h3, 2'h2);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      wr(8'h08, {24'h0, rnd}, 2'h0);
      rd(8'h08, {24'h0, rnd}, 2'h0);
    end
    wr(8'h00, 32'h0, 2'h0);
    wr(8'h08, 32'h0, 2'h0);
    wr(8'h04, 32'h81, 2'h0);
    wr(8'h00, 32'h4, 2'h0);
    wr(8'h00, 32'h2, 2'h0);
    key(8'h80);
    rd(8'h00, 32'h2, 2'h0);
    key(8'h02);
    rd(8'h00, 32'h2, 2'h0);
    key(8'h01);
    chk(34'(key_irq), 34'h1);
    rd(8'h00, 32'h0A, 2'h0);
    wr(8'h00, 32'h6, 2'h0);
    rd(8'h00, 32'h0A, 2'h0);
    key(8'h00);
    wr(8'h00, 32'h6, 2'h0);
    rd(8'h00, 32'h02, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    key(8'h01);
    chk(34'(key_irq), 34'h0);
    rd(8'h00, 32'h08, 2'h0);
    key(8'h00);
    wr(8'h00, 32'hFC, 2'h0);
    rd(8'h00, 32'h00, 2'h0);
    pol <= 8'h01;
    wr(8'h08, 32'h1, 2'h0);
    wr(8'h00, 32'h4, 2'h0);
    wr(8'h00, 32'h2, 2'h0);
    key(8'h01);
    chk(34'(key_irq), 34'h1);
    key(8'h00);
    wr(8'h00, 32'h6, 2'h0);
    wr(8'h04, 32'h0, 2'h0);
    key(8'h01);
    wr(8'h04, 32'h1, 2'h0);
    rd(8'h00, 32'h02, 2'h0);
    wr(8'h00, 32'h3, 2'h0);
    rd(8'h00, 32'h0B, 2'h0);
    key(8'h00);
    wr(8'h00, 32'h6, 2'h0);
    sstop <= 1'b1;
    press <= 8'h01;
    repeat (2) @(posedge aclk);
    chk(34'(wake), 34'h1);
    key(8'h00);
    sstop <= 1'b0;
    dstop <= 1'b1;
    repeat (3) @(posedge aclk);
    dstop <= 1'b0;
    for (int i = 0; i < 3; i++)
      rd(8'(4 * i), 32'h0, 2'h0);
    summarize();
  end
endmodule
